// >>> common/rtcc_pkg.sv
// Constants and types shared by the calendar/alarm/timer core.
// Assumes an 8-bit register port driven by a two-wire bus front end.
package rtcc_pkg;
    // Register addresses
    localparam logic [3:0] A_CTRL1   = 4'h0;
    localparam logic [3:0] A_CTRL2   = 4'h1;
    localparam logic [3:0] A_SEC     = 4'h2;
    localparam logic [3:0] A_MIN     = 4'h3;
    localparam logic [3:0] A_HOUR    = 4'h4;
    localparam logic [3:0] A_DAY     = 4'h5;
    localparam logic [3:0] A_WDAY    = 4'h6;
    localparam logic [3:0] A_MON     = 4'h7;
    localparam logic [3:0] A_YEAR    = 4'h8;
    localparam logic [3:0] A_AL_MIN  = 4'h9;
    localparam logic [3:0] A_AL_HOUR = 4'hA;
    localparam logic [3:0] A_AL_DAY  = 4'hB;
    localparam logic [3:0] A_AL_WDAY = 4'hC;
    localparam logic [3:0] A_FREQ    = 4'hD;
    localparam logic [3:0] A_TCFG    = 4'hE;
    localparam logic [3:0] A_TRELOAD = 4'hF;
    // Bit positions
    localparam int B_TOP     = 7;
    localparam int B_HALT    = 5;
    localparam int B_TEST_LO = 3;
    localparam int B_REPEAT  = 4;
    localparam int B_AF      = 3;
    localparam int B_TF      = 2;
    localparam int B_AIE     = 1;
    localparam int B_TIE     = 0;
    // Writable field masks of the count registers
    localparam logic [7:0] M_SEC  = 8'h7F;
    localparam logic [7:0] M_HOUR = 8'h3F;
    localparam logic [7:0] M_WDAY = 8'h07;
    localparam logic [7:0] M_MON  = 8'h1F;
    // Values after reset
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_ONE  = 8'h01;
    localparam logic [7:0] RST_AL   = 8'h80;
    localparam logic [1:0] RST_FSEL = 2'h0;
    // Prescaler on the 32.768 kHz crystal clock and its taps
    localparam int PRE_W    = 15;
    localparam int TAP_4096 = 2;
    localparam int TAP_1024 = 4;
    localparam int TAP_64   = 8;
    localparam int TAP_32   = 9;
    localparam int TAP_1HZ  = 14;
    // Register port request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } rtcc_req_t;
    // Timer source clock
    typedef enum logic [1:0] {SRC_4096, SRC_64, SRC_1HZ, SRC_1MIN} rtcc_tsrc_t;
    // Square-wave rate
    typedef enum logic [1:0] {SQ_32K, SQ_1024, SQ_32, SQ_1} rtcc_sq_t;
endpackage : rtcc_pkg

// >>> hdl/rtcc_sync.sv
// Two-flop level synchroniser, W bits wide.
// Each bit must be a quasi-static level or a slow flop output.
`timescale 1ns/1ns
module rtcc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         en,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    // First stage is read only by the second stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= '0;
            q        <= '0;
        end else if (en) begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule : rtcc_sync

// >>> hdl/rtcc_core.sv
// Calendar clock with alarm, periodic timer and square-wave output.
// Assumes a bus front end on core_clk and a free 32.768 kHz osc_clk.
`timescale 1ns/1ns

// Functional notes
// - years divisible by four get February 29
// - all time and date counts read and write
// - periodic timer from 244.14 us to 255 min
// - timer event sets period flag, pulls irq low
// - timer irq level mode or repeated pulses
// - alarm match sets alarm flag, pulls irq
// - alarm compares minute/hour/date/weekday with masks
// - square wave pin carries 32.768 kHz directly
// - two-bit select: 32.768k, 1024, 32, 1 Hz
// - reset sets supply-low flag to one
// - other count registers reset to zero, day and month to one
// - reset enables square wave, selects fastest rate
// - gate pin high gives 32.768 kHz by default
// - unused bits read-only, ignore writes
// - counts held as BCD tens/units
// - halt bit stops clock, alarm and timer
// - repeat select chooses single or repeated irq
// - hours count 00 to 23 then wrap
module rtcc_core (
    // Core clock domain
    input  wire logic               core_clk,
    input  wire logic               sys_rst,
    input  wire logic               clk_en,
    // Crystal clock domain
    input  wire logic               osc_clk,
    // Register port
    input  wire rtcc_pkg::rtcc_req_t req,
    output logic              [7:0] rdata,
    // Pins
    input  wire logic               square_wave_gate_pin,
    output logic                    square_wave_pin,
    output logic                    irq_n
);
    import rtcc_pkg::*;

    logic [PRE_W-1:0] pre_reg;
    logic [4:0]       cfg_o;
    logic             halt_o;
    logic             fe_o;
    logic             gate_o;
    logic [1:0]       fsel_o;
    logic             sq_reg;
    logic             sq_en_reg;
    logic [2:0]       tap_s;
    logic [2:0]       tap_d;
    logic [2:0]       tap_rise;
    logic [7:0]       ctrl1_reg;
    logic             halt_reg;
    logic             repeat_reg, af_reg, tf_reg, aie_reg, tie_reg;
    logic             vl_reg;
    logic [7:0]       sec_reg, min_reg, hr_reg, day_reg, wd_reg, mon_reg, yr_reg;
    logic [7:0]       al_min, al_hr, al_day, al_wd;
    logic             fe_reg;
    logic [1:0]       fsel_reg;
    logic             te_reg;
    rtcc_tsrc_t       tsrc_reg;
    logic [7:0]       reload_reg, count_reg;
    logic             sec_step, c_min, c_hr, c_day, c_mon, c_yr;
    logic             t_tick, t_event;
    logic             hit_now, hit_prev, a_event;
    logic             pulse_reg;
    logic             irq_cond;

    // Next BCD value, units wrap 9 to 0 with carry into tens
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    endfunction : bcd_inc

    // Leap test on a BCD year
    function automatic logic is_leap(input logic [7:0] y);
        if (y[4])
            return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
        return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    endfunction : is_leap

    // Last BCD day of a month
    function automatic logic [7:0] last_day(input logic [7:0] m, input logic [7:0] y);
        case (m)
            8'h02:   return is_leap(y) ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
            default: return 8'h31;
        endcase
    endfunction : last_day

    function automatic logic wr_at(input rtcc_req_t r, input logic [3:0] a);
        return r.wr && (r.addr == a);
    endfunction : wr_at

    // ---------------- Crystal domain ----------------
    // Config and gate pin cross as levels; a rate change may glitch one cycle
    rtcc_sync #(.W(5)) u_cfg_sync (
        .clk (osc_clk),
        .rst (sys_rst),
        .en  (1'b1),
        .d   ({halt_reg, fe_reg, fsel_reg, square_wave_gate_pin}),
        .q   (cfg_o)
    );
    assign {halt_o, fe_o, fsel_o, gate_o} = cfg_o;

    // Prescaler is cleared while halted so the first second after restart is half long
    always_ff @(posedge osc_clk or posedge sys_rst) begin
        if (sys_rst)
            pre_reg <= '0;
        else if (halt_o)
            pre_reg <= '0;
        else
            pre_reg <= pre_reg + 15'h0001;
    end

    // Divided square wave, stops with the prescaler when halted
    always_ff @(posedge osc_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sq_reg    <= 1'b0;
            sq_en_reg <= 1'b0;
        end else begin
            sq_en_reg <= fe_o && gate_o;
            case (rtcc_sq_t'(fsel_o))
                SQ_1024: sq_reg <= pre_reg[TAP_1024];
                SQ_32:   sq_reg <= pre_reg[TAP_32];
                SQ_1:    sq_reg <= pre_reg[TAP_1HZ];
                default: sq_reg <= 1'b0;
            endcase
        end
    end

    // Full rate passes the crystal clock itself, so it keeps running when halted
    assign square_wave_pin = sq_en_reg &&
                             ((fsel_o == 2'(SQ_32K)) ? osc_clk : sq_reg);

    // ---------------- Core domain ----------------
    // Prescaler taps are single flop bits, safe to synchronise as levels
    rtcc_sync #(.W(3)) u_tap_sync (
        .clk (core_clk),
        .rst (sys_rst),
        .en  (clk_en),
        .d   ({pre_reg[TAP_1HZ], pre_reg[TAP_64], pre_reg[TAP_4096]}),
        .q   (tap_s)
    );

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst)
            tap_d <= '0;
        else if (clk_en)
            tap_d <= tap_s;
    end
    assign tap_rise = tap_s & ~tap_d;

    // Carry chain of the calendar
    always_comb begin
        sec_step = tap_rise[2] && !halt_reg;
        c_min    = sec_step && (sec_reg == 8'h59);
        c_hr     = c_min && (min_reg == 8'h59);
        c_day    = c_hr && (hr_reg == 8'h23);
        // Century bit is kept out of the month compare, or February breaks after 99
        c_mon    = c_day && (day_reg == last_day({3'h0, mon_reg[4:0]}, yr_reg));
        c_yr     = c_mon && (mon_reg[4:0] == 5'h12);
    end

    // Time and date counts; a host write wins over a tick on the same count
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            vl_reg  <= 1'b1;
            sec_reg <= RST_ZERO;
            min_reg <= RST_ZERO;
            hr_reg  <= RST_ZERO;
            day_reg <= RST_ONE;
            wd_reg  <= RST_ZERO;
            mon_reg <= RST_ONE;
            yr_reg  <= RST_ZERO;
        end else if (clk_en) begin
            if (sec_step)
                sec_reg <= c_min ? 8'h00 : bcd_inc(sec_reg);
            if (c_min)
                min_reg <= c_hr ? 8'h00 : bcd_inc(min_reg);
            if (c_hr)
                hr_reg <= c_day ? 8'h00 : bcd_inc(hr_reg);
            if (c_day) begin
                day_reg <= c_mon ? 8'h01 : bcd_inc(day_reg);
                wd_reg  <= (wd_reg == 8'h06) ? 8'h00 : wd_reg + 8'h01;
            end
            if (c_mon)
                mon_reg <= c_yr ? {mon_reg[B_TOP], 7'h01} : bcd_inc(mon_reg);
            if (c_yr) begin
                yr_reg  <= (yr_reg == 8'h99) ? 8'h00 : bcd_inc(yr_reg);
                mon_reg <= {~mon_reg[B_TOP] ^ (yr_reg != 8'h99), 7'h01};
            end
            if (wr_at(req, A_SEC)) begin
                vl_reg  <= req.wdata[B_TOP];
                sec_reg <= req.wdata & M_SEC;
            end
            if (wr_at(req, A_MIN))
                min_reg <= req.wdata & M_SEC;
            if (wr_at(req, A_HOUR))
                hr_reg <= req.wdata & M_HOUR;
            if (wr_at(req, A_DAY))
                day_reg <= req.wdata & M_HOUR;
            if (wr_at(req, A_WDAY))
                wd_reg <= req.wdata & M_WDAY;
            if (wr_at(req, A_MON))
                mon_reg <= req.wdata & (M_MON | RST_AL);
            if (wr_at(req, A_YEAR))
                yr_reg <= req.wdata;
        end
    end

    // Control, alarm and output configuration
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl1_reg  <= RST_ZERO;
            repeat_reg <= 1'b0;
            aie_reg    <= 1'b0;
            tie_reg    <= 1'b0;
            al_min     <= RST_AL;
            al_hr      <= RST_AL;
            al_day     <= RST_AL;
            al_wd      <= RST_AL;
            fe_reg     <= 1'b1;
            fsel_reg   <= RST_FSEL;
            te_reg     <= 1'b0;
            tsrc_reg   <= SRC_4096;
            reload_reg <= RST_ZERO;
        end else if (clk_en) begin
            if (wr_at(req, A_CTRL1))
                ctrl1_reg <= req.wdata & {1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 3'h0};
            if (wr_at(req, A_CTRL2)) begin
                repeat_reg <= req.wdata[B_REPEAT];
                aie_reg    <= req.wdata[B_AIE];
                tie_reg    <= req.wdata[B_TIE];
            end
            if (wr_at(req, A_AL_MIN))
                al_min <= req.wdata;
            if (wr_at(req, A_AL_HOUR))
                al_hr <= req.wdata & (M_HOUR | RST_AL);
            if (wr_at(req, A_AL_DAY))
                al_day <= req.wdata & (M_HOUR | RST_AL);
            if (wr_at(req, A_AL_WDAY))
                al_wd <= req.wdata & (M_WDAY | RST_AL);
            if (wr_at(req, A_FREQ)) begin
                fe_reg   <= req.wdata[B_TOP];
                fsel_reg <= req.wdata[1:0];
            end
            if (wr_at(req, A_TCFG)) begin
                te_reg   <= req.wdata[B_TOP];
                tsrc_reg <= rtcc_tsrc_t'(req.wdata[1:0]);
            end
            if (wr_at(req, A_TRELOAD))
                reload_reg <= req.wdata;
        end
    end
    assign halt_reg = ctrl1_reg[B_HALT];

    // Timer source selection
    always_comb begin
        case (tsrc_reg)
            SRC_4096: t_tick = tap_rise[0];
            SRC_64:   t_tick = tap_rise[1];
            SRC_1HZ:  t_tick = tap_rise[2];
            default:  t_tick = c_min;
        endcase
        t_tick  = t_tick && te_reg && !halt_reg;
        t_event = t_tick && (reload_reg != 8'h00) && (count_reg <= 8'h01);
    end

    // Down counter, reloaded on each event and on a host write
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst)
            count_reg <= RST_ZERO;
        else if (clk_en) begin
            if (wr_at(req, A_TRELOAD))
                count_reg <= req.wdata;
            else if (t_event)
                count_reg <= reload_reg;
            else if (t_tick && count_reg != 8'h00)
                count_reg <= count_reg - 8'h01;
        end
    end

    // Alarm fires on entering a match; a set mask bit drops that field
    always_comb begin
        hit_now = (al_min[B_TOP] || al_min[6:0] == min_reg[6:0]) &&
                  (al_hr[B_TOP]  || al_hr[5:0]  == hr_reg[5:0]) &&
                  (al_day[B_TOP] || al_day[5:0] == day_reg[5:0]) &&
                  (al_wd[B_TOP]  || al_wd[2:0]  == wd_reg[2:0]) &&
                  !(al_min[B_TOP] && al_hr[B_TOP] && al_day[B_TOP] && al_wd[B_TOP]) &&
                  !halt_reg;
        a_event = hit_now && !hit_prev;
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst)
            hit_prev <= 1'b0;
        else if (clk_en)
            hit_prev <= hit_now;
    end

    // Flags: host clears by writing zero, an event in the same cycle wins
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            af_reg <= 1'b0;
            tf_reg <= 1'b0;
        end else if (clk_en) begin
            if (wr_at(req, A_CTRL2) && !req.wdata[B_AF])
                af_reg <= 1'b0;
            if (wr_at(req, A_CTRL2) && !req.wdata[B_TF])
                tf_reg <= 1'b0;
            if (a_event)
                af_reg <= 1'b1;
            if (t_event)
                tf_reg <= 1'b1;
        end
    end

    // Repeat mode gives a short pulse per period, cleared on the next 4096 Hz edge
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst)
            pulse_reg <= 1'b0;
        else if (clk_en) begin
            if (t_event && repeat_reg)
                pulse_reg <= 1'b1;
            else if (tap_rise[0])
                pulse_reg <= 1'b0;
        end
    end

    assign irq_cond = (af_reg && aie_reg) ||
                      (tie_reg && (repeat_reg ? pulse_reg : tf_reg));

    // Interrupt pin is registered to keep it glitch free
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst)
            irq_n <= 1'b1;
        else if (clk_en)
            irq_n <= !irq_cond;
    end

    // Read data, one cycle after the request; unused bits read zero
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst)
            rdata <= RST_ZERO;
        else if (clk_en && req.rd) begin
            case (req.addr)
                A_CTRL1:   rdata <= ctrl1_reg;
                A_CTRL2:   rdata <= {3'h0, repeat_reg, af_reg, tf_reg, aie_reg, tie_reg};
                A_SEC:     rdata <= {vl_reg, sec_reg[6:0]};
                A_MIN:     rdata <= min_reg;
                A_HOUR:    rdata <= hr_reg;
                A_DAY:     rdata <= day_reg;
                A_WDAY:    rdata <= wd_reg;
                A_MON:     rdata <= mon_reg;
                A_YEAR:    rdata <= yr_reg;
                A_AL_MIN:  rdata <= al_min;
                A_AL_HOUR: rdata <= al_hr;
                A_AL_DAY:  rdata <= al_day;
                A_AL_WDAY: rdata <= al_wd;
                A_FREQ:    rdata <= {fe_reg, 5'h00, fsel_reg};
                A_TCFG:    rdata <= {te_reg, 5'h00, 2'(tsrc_reg)};
                default:   rdata <= reload_reg;
            endcase
        end
    end

    // ---------------- Checks ----------------
    sequence s_leap_roll;
        clk_en && !req.wr && c_day && mon_reg == 8'h02 && day_reg == 8'h28 && is_leap(yr_reg);
    endsequence
    property p_leap;
        @(posedge core_clk) disable iff (sys_rst) s_leap_roll |=> day_reg == 8'h29;
    endproperty
    a_leap: assert property (p_leap) else $error("leap day skipped");

    property p_reload;
        @(posedge core_clk) disable iff (sys_rst)
            clk_en && !req.wr && t_event |=> count_reg == $past(reload_reg);
    endproperty
    a_reload: assert property (p_reload) else $error("timer not reloaded");

    property p_tf;
        @(posedge core_clk) disable iff (sys_rst)
            clk_en && t_event |=> tf_reg and ((clk_en && tie_reg && !repeat_reg) |=> !irq_n);
    endproperty
    a_tf: assert property (p_tf) else $error("period flag or irq missing");

    sequence s_rep_event;
        clk_en && t_event && repeat_reg && tie_reg;
    endsequence
    property p_repeat;
        @(posedge core_clk) disable iff (sys_rst) s_rep_event ##1 clk_en |=> !irq_n;
    endproperty
    a_repeat: assert property (p_repeat) else $error("repeat pulse missing");

    property p_af;
        @(posedge core_clk) disable iff (sys_rst) clk_en && a_event |=> af_reg;
    endproperty
    a_af: assert property (p_af) else $error("alarm flag not set");

    property p_halt;
        @(posedge core_clk) disable iff (sys_rst)
            (halt_reg && !req.wr)[*2] |-> $stable(sec_reg) && $stable(count_reg) && !a_event;
    endproperty
    a_halt: assert property (p_halt) else $error("counting while halted");

    property p_hour_wrap;
        @(posedge core_clk) disable iff (sys_rst)
            clk_en && !req.wr && c_day |=> hr_reg == 8'h00 && min_reg == 8'h00;
    endproperty
    a_hour_wrap: assert property (p_hour_wrap) else $error("hour did not wrap");

    property p_bcd;
        @(posedge core_clk) disable iff (sys_rst)
            clk_en && !req.wr && sec_step && sec_reg[3:0] == 4'h9 |=> sec_reg[3:0] == 4'h0;
    endproperty
    a_bcd: assert property (p_bcd) else $error("seconds not BCD");

    property p_irq_gate;
        @(posedge core_clk) disable iff (sys_rst)
            clk_en && !aie_reg && !tie_reg |=> irq_n;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");
endmodule : rtcc_core

// >>> tb/rtcc_host.sv
// Host-side model of the register port: single-cycle read and write strobes.
// Assumes requests are taken on rising core_clk, read data one cycle later.
`timescale 1ns/1ns
module rtcc_host (
    // Clock
    input  wire logic                 core_clk,
    // Register port
    output rtcc_pkg::rtcc_req_t       req,
    input  wire logic           [7:0] rdata
);
    import rtcc_pkg::*;

    initial req = '0;

    // Write; control_primary keeps only the halt bit, test and zero bits at 0
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = (a == A_CTRL1) ? (d & 8'h20) : d;
        @(posedge core_clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge core_clk);
        req.wr <= 1'b0;
    endtask : wr

    // Read; strobe dropped at the taking edge, data taken at the next edge where it stands
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge core_clk);
        req.rd <= 1'b0;
        @(posedge core_clk);
        d = rdata;
    endtask : rd
endmodule : rtcc_host

// >>> tb/tb.sv
// Self-checking bench for the calendar core: registers, square wave, timer, alarm.
// Assumes a 32 ns crystal clock so half a second is 16384 crystal cycles.
`timescale 1ns/1ns
module tb;
    import rtcc_pkg::*;
    logic       core_clk, osc_clk, sys_rst, gate, sq, irq_n;
    rtcc_req_t  req;
    logic [7:0] rdata, d;
    int         n_fail, total_checks, edges, i;
    // Clock set-up as the host would write it, then the values expected back
    logic [3:0] ta [7] = '{A_SEC, A_MIN, A_HOUR, A_DAY, A_WDAY, A_MON, A_YEAR};
    logic [7:0] tv [7] = '{8'h59, 8'h59, 8'hE3, 8'h28, 8'h06, 8'h02, 8'h24};
    logic [7:0] te [7] = '{8'h59, 8'h59, 8'h23, 8'h28, 8'h06, 8'h02, 8'h24};

    rtcc_core dut (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(1'b1),
        .osc_clk(osc_clk), .req(req), .rdata(rdata), .square_wave_gate_pin(gate),
        .square_wave_pin(sq), .irq_n(irq_n));
    rtcc_host host (.core_clk(core_clk), .req(req), .rdata(rdata));

    // Two unrelated clocks
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        osc_clk = 1'b0;
        #7;
        forever #16 osc_clk = ~osc_clk;
    end
    // Square-wave edge counter
    always @(posedge sq) edges++;

    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Masked read, unused bits dropped before comparing
    task automatic rchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        host.rd(a, d);
        chk(d & m, e);
    endtask : rchk

    // Bounded wait for the interrupt pin, sampled on falling edges; a miss ends the run
    task automatic wait_irq(input logic lvl);
        @(negedge core_clk);
        for (int k = 0; k < 3000 && irq_n !== lvl; k++) @(negedge core_clk);
        chk({7'h00, irq_n}, {7'h00, lvl});
        if (irq_n !== lvl) conclude();
    endtask : wait_irq

    // Settle, then count square-wave rises over n crystal cycles
    task automatic sq_cnt(input int n, input int lo, input int hi);
        repeat (8) @(posedge osc_clk);
        edges = 0;
        repeat (n) @(posedge osc_clk);
        chk({7'h00, (edges >= lo && edges <= hi)}, 8'h01);
    endtask : sq_cnt

    // Hang guard
    initial begin
        #1000000;
        n_fail++;
        conclude();
    end

    // Main sequence
    initial begin
        sys_rst = 1'b1;
        gate = 1'b1;
        n_fail = 0;
        total_checks = 0;
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        rchk(A_SEC, 8'h80, 8'h80);
        rchk(A_FREQ, 8'h83, 8'h80);
        sq_cnt(64, 62, 65);
        $display("test reset_and_default_wave done");
        host.wr(A_FREQ, 8'h81);
        sq_cnt(256, 7, 9);
        host.wr(A_FREQ, 8'h82);
        sq_cnt(2048, 1, 3);
        @(posedge core_clk);
        gate <= 1'b0;
        sq_cnt(64, 0, 0);
        @(posedge core_clk);
        gate <= 1'b1;
        host.wr(A_FREQ, 8'h81);
        host.wr(A_CTRL1, 8'hA8);
        sq_cnt(256, 0, 0);
        host.wr(A_FREQ, 8'h80);
        sq_cnt(64, 62, 65);
        $display("test wave_rates done");
        for (i = 0; i < 7; i++) host.wr(ta[i], tv[i]);
        for (i = 0; i < 7; i++) rchk(ta[i], 8'hFF, te[i]);
        host.wr(A_CTRL1, 8'h00);
        repeat (16500) @(posedge osc_clk);
        rchk(A_DAY, 8'h3F, 8'h29);
        rchk(A_HOUR, 8'h3F, 8'h00);
        rchk(A_MIN, 8'h7F, 8'h00);
        rchk(A_WDAY, 8'h07, 8'h00);
        $display("test leap_rollover done");
        host.wr(A_TRELOAD, 8'h02);
        host.wr(A_TCFG, 8'h80);
        repeat (150) @(posedge core_clk);
        chk({7'h00, irq_n}, 8'h01);
        rchk(A_CTRL2, 8'h04, 8'h04);
        host.wr(A_CTRL2, 8'h01);
        wait_irq(1'b0);
        // Slower 64 Hz source, one tick per event
        host.wr(A_TCFG, 8'h81);
        host.wr(A_TRELOAD, 8'h01);
        host.wr(A_CTRL2, 8'h01);
        wait_irq(1'b1);
        wait_irq(1'b0);
        host.wr(A_TCFG, 8'h00);
        host.wr(A_TRELOAD, 8'h02);
        host.wr(A_CTRL2, 8'h00);
        wait_irq(1'b1);
        rchk(A_CTRL2, 8'h04, 8'h00);
        host.wr(A_CTRL2, 8'h11);
        host.wr(A_TCFG, 8'h80);
        wait_irq(1'b0);
        wait_irq(1'b1);
        host.wr(A_TCFG, 8'h00);
        $display("test period_timer done");
        host.wr(A_CTRL2, 8'h02);
        host.wr(A_AL_MIN, 8'h00);
        wait_irq(1'b0);
        rchk(A_CTRL2, 8'h08, 8'h08);
        $display("test alarm done");
        conclude();
    end
endmodule : tb
